// file: logic/dac_ctrl_pkg.sv
package dac_ctrl_pkg;
  localparam int CODE_W = 14;
  localparam int NUM_CH = 8;
  localparam int MON_W = 12;
  // Word indices; byte address is four times the index
  localparam logic [4:0] IDX_CONFIG = 5'h00;
  localparam logic [4:0] IDX_MONITOR = 5'h01;
  localparam logic [4:0] IDX_PIN = 5'h02;
  localparam logic [4:0] IDX_BUSY = 5'h05;
  localparam logic [1:0] GRP_DATA = 2'h1;
  localparam logic [1:0] GRP_ZERO = 2'h2;
  localparam logic [1:0] GRP_GAIN = 2'h3;
  // Field positions
  localparam int CFG_READBACK_BIT = 13;
  localparam int CFG_CALIB_BIT = 8;
  localparam int CFG_GBF_BIT = 7;
  localparam int PIN_BIT = 13;
  localparam int BUSY_LSB = 6;
  localparam int MON_LSB = 2;
  // Values after reset
  localparam logic [13:0] RST_CODE = 14'h0000;
  localparam logic [13:0] RST_ZERO = 14'h0000;
  localparam logic [13:0] RST_GAIN = 14'h2000;
  localparam logic [11:0] RST_MONITOR = 12'h000;
  localparam logic RST_READBACK = 1'b1;
  localparam logic RST_CALIB = 1'b0;
  localparam logic RST_PIN = 1'b1;
  // Correction arithmetic
  localparam logic [14:0] GAIN_HALF = 15'h2000;
  localparam logic [13:0] CODE_MAX = 14'h3fff;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int CORR_TIME_NS = 500;
  localparam int CORR_CYCLES = (CORR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [13:0] code;
    logic [13:0] gain;
    logic [13:0] zero;
  } corr_req_s;
endpackage

// file: logic/two_flop_sync.sv
`timescale 1ns/1ps
module two_flop_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage <= '0;
      q <= '0;
    end else begin
      stage <= d;
      q <= stage;
    end
  end
endmodule

// file: logic/correction_engine.sv
`timescale 1ns/1ps
module correction_engine #(
  parameter int CYCLES = dac_ctrl_pkg::CORR_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire dac_ctrl_pkg::corr_req_s req,
  output logic busy,
  output logic done,
  output logic [13:0] result
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt;
  dac_ctrl_pkg::corr_req_s held;

  // Code times (0.5 + gain/16384) plus signed zero, clamped
  function automatic logic [13:0] correct(input dac_ctrl_pkg::corr_req_s r);
    logic [29:0] prod;
    logic signed [16:0] sum;
    prod = 30'(r.code) * 30'({1'b0, r.gain} + dac_ctrl_pkg::GAIN_HALF);
    sum = $signed({2'b00, prod[28:14]}) + $signed({{3{r.zero[13]}}, r.zero});
    if (sum < 0) begin
      correct = 14'h0000;
    end else if (sum > $signed({3'b000, dac_ctrl_pkg::CODE_MAX})) begin
      correct = dac_ctrl_pkg::CODE_MAX;
    end else begin
      correct = sum[13:0];
    end
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= '0;
      held <= '0;
      result <= 14'h0000;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        held <= req;
        cnt <= '0;
      end else if (busy && cnt == LAST) begin
        busy <= 1'b0;
        done <= 1'b1; // [RULE19]
        result <= correct(held); // [RULE12]
      end else if (busy) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  unity_gain_pass_a: assert property ((!busy && start && req.gain == dac_ctrl_pkg::RST_GAIN
      && req.zero == 14'h0000) ##[1:40] done |-> result == held.code) // [RULE12]
    else $error("unity gain and zero offset changed the code");
  finish_time_a: assert property (!busy && start |-> ##[1:40] done) // [RULE19]
    else $error("correction did not finish in time");
endmodule

// file: logic/dac_monitor_calib_gpio_regs.sv
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
// Contract
// RULE1: One-hot monitor bits route refB, refA, offB, offA, then channels 0 to 7.
// RULE2: The bit between channel 2 and channel 4 selects channel 3.
// RULE3: Zero or multi-bit monitor codes disable the monitor, output high impedance.
// RULE4: Invalid monitor codes are still stored and read back as written.
// RULE5: Don't-care bits of monitor, pin and busy registers ignore writes, read zero.
// RULE6: Calibration on stores code in input register; off writes converter register.
// RULE7: Input data registers reset to zero.
// RULE8: Calibration enable corrects input data with gain and zero before converter.
// RULE9: Readback select picks input register (clear) or converter register (set).
// RULE10: Zero register is 14-bit two's complement offset, resets to zero.
// RULE11: Gain register is straight binary 0.5 to 1.5, resets to 2000h.
// RULE12: Output equals code times (0.5 + gain/16384) plus zero, clamped.
// RULE13: Pin bit one releases the pin, zero drives it low.
// RULE14: Reading the pin bit returns the sampled pin level.
// RULE15: After reset pin bit is one and pin released.
// RULE16: Busy flags for channels 7..0 sit in bits 13..6, read-only, reset zero.
// RULE17: With calibration on, data, zero or gain writes set the channel busy flag.
// RULE18: Busy flag clears when corrected code reaches the converter register; here the flag clears one cycle before that load.
// RULE19: Each channel correction takes about 500 ns.
// RULE20: All busy flags read zero while calibration is off.
module dac_monitor_calib_gpio_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [6:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic gpio_in,
  output logic gpio_out,
  output logic gpio_oe_b,
  output logic [11:0] mon_route,
  output logic mon_hiz,
  output logic [7:0][13:0] dac_code,
  output logic calib_enable
);
  function automatic logic [7:0] onehot8(input logic [2:0] n);
    onehot8 = 8'h01 << n;
  endfunction

  function automatic logic [2:0] lowest_set(input logic [7:0] v);
    lowest_set = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = 3'(i);
      end
    end
  endfunction

  logic readback_sel;
  logic [11:0] mon_bits;
  logic pin_release;
  logic [13:0] input_data [8];
  logic [13:0] zero_offset [8];
  logic [13:0] gain_trim [8];
  logic [7:0] pending;
  logic [2:0] inflight;
  logic pin_level;
  logic eng_busy;
  logic eng_done;
  logic [13:0] eng_result;

  // Bus decode
  wire acc = cyc_i & stb_i;
  wire wr = acc & we_i & ack_o & (&sel_i[1:0]);
  wire [4:0] idx = adr_i[6:2];
  wire [2:0] ch = idx[2:0];
  wire [1:0] grp = idx[4:3];
  wire is_data = grp == dac_ctrl_pkg::GRP_DATA;
  wire is_zero = grp == dac_ctrl_pkg::GRP_ZERO;
  wire is_gain = grp == dac_ctrl_pkg::GRP_GAIN;
  wire is_cfg = idx == dac_ctrl_pkg::IDX_CONFIG;
  wire is_mon = idx == dac_ctrl_pkg::IDX_MONITOR;
  wire is_pin = idx == dac_ctrl_pkg::IDX_PIN;
  wire is_busy = idx == dac_ctrl_pkg::IDX_BUSY;
  wire [13:0] wdat = dat_i[13:0];

  // Correction scheduling
  wire [7:0] set_vec = (calib_enable && wr && (is_data || is_zero || is_gain)) ?
      onehot8(ch) : 8'h00; // [RULE17]
  wire start = calib_enable & ~eng_busy & (|pending);
  wire [2:0] pick = lowest_set(pending);
  wire [7:0] clr_vec = start ? onehot8(pick) : 8'h00;
  wire [7:0] next_pending = calib_enable ? ((pending & ~clr_vec) | set_vec) : 8'h00;
  wire [7:0] busy_flags = calib_enable ?
      (pending | (eng_busy ? onehot8(inflight) : 8'h00)) : 8'h00; // [RULE18] [RULE20]
  wire gbf = |busy_flags;
  wire dbg_unused = &{dat_i[31:14], sel_i[3:2]};
  dac_ctrl_pkg::corr_req_s req;
  assign req.code = input_data[pick];
  assign req.gain = gain_trim[pick];
  assign req.zero = zero_offset[pick];

  // Monitor selection
  wire mon_valid = $onehot(mon_bits); // [RULE3]

  // Read mux
  wire [13:0] cfg_word = {readback_sel, 4'h0, calib_enable, gbf, 7'h00};
  wire [13:0] data_word = readback_sel ? dac_code[ch] : input_data[ch]; // [RULE9]
  wire [13:0] read_word =
      is_cfg ? cfg_word :
      is_mon ? {mon_bits, 2'b00} : // [RULE4] [RULE5]
      is_pin ? {pin_level, 13'h0000} : // [RULE14]
      is_busy ? {busy_flags, 6'h00} : // [RULE16]
      is_data ? data_word :
      is_zero ? zero_offset[ch] :
      is_gain ? gain_trim[ch] : 14'h0000;
  wire [31:0] next_dat = (acc && !ack_o && !we_i) ? {18'h00000, read_word} : 32'h00000000;

  two_flop_sync #(.W(1)) pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(gpio_in),
    .q(pin_level)
  );

  correction_engine #(.CYCLES(dac_ctrl_pkg::CORR_CYCLES)) engine (
    .clk(clk),
    .rst_b(rst_b),
    .start(start), // [RULE8]
    .req(req),
    .busy(eng_busy),
    .done(eng_done),
    .result(eng_result)
  );

  // Bus handshake
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= acc & ~ack_o;
      dat_o <= next_dat;
    end
  end

  // Configuration
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readback_sel <= dac_ctrl_pkg::RST_READBACK;
      calib_enable <= dac_ctrl_pkg::RST_CALIB;
    end else if (wr && is_cfg) begin
      readback_sel <= wdat[dac_ctrl_pkg::CFG_READBACK_BIT];
      calib_enable <= wdat[dac_ctrl_pkg::CFG_CALIB_BIT]; // [RULE8]
    end
  end

  // Monitor code and route
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mon_bits <= dac_ctrl_pkg::RST_MONITOR;
      mon_route <= 12'h000;
      mon_hiz <= 1'b1;
    end else begin
      if (wr && is_mon) begin
        mon_bits <= wdat[13:dac_ctrl_pkg::MON_LSB]; // [RULE4] [RULE5]
      end
      mon_route <= mon_valid ? mon_bits : 12'h000; // [RULE1] [RULE2]
      mon_hiz <= ~mon_valid; // [RULE3]
    end
  end

  // Open-drain pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_release <= dac_ctrl_pkg::RST_PIN; // [RULE15]
      gpio_oe_b <= 1'b1;
      gpio_out <= 1'b0;
    end else begin
      if (wr && is_pin) begin
        pin_release <= wdat[dac_ctrl_pkg::PIN_BIT]; // [RULE13]
      end
      gpio_oe_b <= pin_release; // [RULE13]
      gpio_out <= 1'b0;
    end
  end

  // Busy tracking
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending <= 8'h00;
      inflight <= 3'h0;
    end else begin
      pending <= next_pending; // [RULE17] [RULE20]
      if (start) begin
        inflight <= pick;
      end
    end
  end

  // Channel registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < dac_ctrl_pkg::NUM_CH; i++) begin
        input_data[i] <= dac_ctrl_pkg::RST_CODE; // [RULE7]
        zero_offset[i] <= dac_ctrl_pkg::RST_ZERO; // [RULE10]
        gain_trim[i] <= dac_ctrl_pkg::RST_GAIN; // [RULE11]
        dac_code[i] <= dac_ctrl_pkg::RST_CODE;
      end
    end else begin
      if (wr && is_data && calib_enable) begin
        input_data[ch] <= wdat; // [RULE6]
      end
      if (wr && is_zero) begin
        zero_offset[ch] <= wdat; // [RULE10]
      end
      if (wr && is_gain) begin
        gain_trim[ch] <= wdat; // [RULE11]
      end
      if (wr && is_data && !calib_enable) begin
        dac_code[ch] <= wdat; // [RULE6]
      end else if (eng_done && calib_enable) begin
        dac_code[inflight] <= eng_result; // [RULE8] [RULE18]
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence write_to(logic [4:0] i);
    wr && idx == i;
  endsequence

  sequence chan_write;
    calib_enable && wr && (is_data || is_zero || is_gain);
  endsequence

  sequence read_req(logic [4:0] i);
    acc && !we_i && !ack_o && idx == i;
  endsequence

  sequence data_read(logic sel);
    acc && !we_i && !ack_o && is_data && readback_sel == sel;
  endsequence

  sequence trim_read(logic [1:0] g);
    acc && !we_i && !ack_o && grp == g;
  endsequence

  sequence chan_done;
    eng_done && calib_enable;
  endsequence

  monitor_invalid_hiz_a: assert property (!$onehot(mon_bits) |=> mon_hiz && mon_route == 12'h000) // [RULE3]
    else $error("invalid monitor code did not release the output");
  monitor_route_a: assert property ($onehot(mon_bits) |=> !mon_hiz
      && mon_route == $past(mon_bits)) // [RULE1]
    else $error("monitor route does not follow the code");
  monitor_chan3_a: assert property (mon_bits == 12'h080 |=> mon_route[7]) // [RULE2]
    else $error("channel 3 monitor bit not routed");
  monitor_stored_a: assert property (write_to(dac_ctrl_pkg::IDX_MONITOR) |=>
      mon_bits == $past(wdat[13:2])) // [RULE4]
    else $error("monitor code not stored as written");
  busy_set_a: assert property (chan_write |=> busy_flags[$past(ch)]) // [RULE17]
    else $error("channel write did not raise busy");
  busy_off_a: assert property (!calib_enable |-> busy_flags == 8'h00) // [RULE20]
    else $error("busy flag seen with calibration off");
  direct_write_a: assert property (wr && is_data && !calib_enable |=>
      dac_code[$past(ch)] == $past(wdat)) // [RULE6]
    else $error("direct write missed the converter register");
  pin_drive_a: assert property (write_to(dac_ctrl_pkg::IDX_PIN) ##1 !wr |=>
      gpio_oe_b == $past(pin_release)) // [RULE13]
    else $error("pin enable does not follow the pin bit");
  pin_read_a: assert property (acc && !we_i && !ack_o && is_pin |=>
      dat_o[13] == $past(pin_level) && dat_o[12:0] == 13'h0000) // [RULE14]
    else $error("pin read does not show the pin level");
  busy_read_a: assert property (acc && !we_i && !ack_o && is_busy |=>
      dat_o[5:0] == 6'h00 && dat_o[13:6] == $past(busy_flags)) // [RULE16]
    else $error("busy register read wrong");
  busy_clear_a: assert property (start ##1 (!wr)[*8] |-> ##[1:40] !eng_busy) // [RULE19]
    else $error("correction did not complete in time");

  // Bus handshake checks
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("acknowledge held for more than one cycle");
  ack_follow_a: assert property (acc && !ack_o |=> ack_o)
    else $error("request not acknowledged in the next cycle");
  ack_idle_a: assert property (!acc |=> !ack_o)
    else $error("acknowledge without a request");
  read_upper_a: assert property (dat_o[31:14] == 18'h00000) // [RULE5]
    else $error("unused read data bits not zero");

  // Monitor checks
  monitor_read_a: assert property (read_req(dac_ctrl_pkg::IDX_MONITOR) |=> // [RULE4]
      dat_o[13:0] == {$past(mon_bits), 2'b00})
    else $error("monitor readback differs from stored code");
  monitor_onehot_a: assert property (!mon_hiz |-> $onehot(mon_route)) // [RULE1]
    else $error("active monitor route not one-hot");
  monitor_hiz_zero_a: assert property (mon_hiz |-> mon_route == 12'h000) // [RULE3]
    else $error("released monitor still routes a source");
  monitor_off_a: assert property (mon_bits == 12'h000 |=> mon_hiz) // [RULE3]
    else $error("cleared monitor code did not release the output");

  // Readback checks
  config_read_a: assert property (read_req(dac_ctrl_pkg::IDX_CONFIG) |=> // [RULE9]
      dat_o[13] == $past(readback_sel) && dat_o[8] == $past(calib_enable)
      && dat_o[12:9] == 4'h0 && dat_o[6:0] == 7'h00)
    else $error("configuration readback wrong");
  data_read_a: assert property (data_read(1'b1) |=> // [RULE9]
      dat_o[13:0] == $past(dac_code[ch]))
    else $error("converter register readback wrong");
  input_read_a: assert property (data_read(1'b0) |=> // [RULE9]
      dat_o[13:0] == $past(input_data[ch]))
    else $error("input register readback wrong");
  zero_read_a: assert property (trim_read(dac_ctrl_pkg::GRP_ZERO) |=> // [RULE10]
      dat_o[13:0] == $past(zero_offset[ch]))
    else $error("zero register readback wrong");
  gain_read_a: assert property (trim_read(dac_ctrl_pkg::GRP_GAIN) |=> // [RULE11]
      dat_o[13:0] == $past(gain_trim[ch]))
    else $error("gain register readback wrong");

  // Store and correction checks
  calib_store_a: assert property (wr && is_data && calib_enable |=> // [RULE6]
      input_data[$past(ch)] == $past(wdat))
    else $error("calibrated write missed the input register");
  zero_store_a: assert property (wr && is_zero |=> // [RULE10]
      zero_offset[$past(ch)] == $past(wdat))
    else $error("zero register not stored");
  gain_store_a: assert property (wr && is_gain |=> // [RULE11]
      gain_trim[$past(ch)] == $past(wdat))
    else $error("gain register not stored");
  corrected_load_a: assert property (chan_done |=> // [RULE18]
      dac_code[$past(inflight)] == $past(eng_result))
    else $error("corrected code not loaded into converter register");
  engine_start_a: assert property (start |=> eng_busy) // [RULE17]
    else $error("pending channel did not start the engine");
  inflight_busy_a: assert property (calib_enable && eng_busy |-> busy_flags[inflight]) // [RULE18]
    else $error("channel under correction not flagged busy");
  pin_low_drive_a: assert property (gpio_out == 1'b0) // [RULE13]
    else $error("pin driven high");
endmodule

// file: verification/pin_pullup_model.sv
`timescale 1ns/1ps
module pin_pullup_model (
  input wire logic gpio_out,
  input wire logic gpio_oe_b,
  input wire logic ext_low,
  output logic pin
);
  // Board pull-up holds the line high unless someone sinks it
  assign pin = (!gpio_oe_b) ? gpio_out : !ext_low;
endmodule

// file: verification/test_dac_monitor_calib_gpio_regs.sv
`timescale 1ns/1ps
module test_dac_monitor_calib_gpio_regs;
  logic clk, rst_b, cyc_i, stb_i, we_i, ack_o, gpio_in, gpio_out, gpio_oe_b;
  logic mon_hiz, calib_enable, ext_low;
  logic [6:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [11:0] mon_route;
  logic [7:0][13:0] dac_code;
  int error_cnt, checks;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  dac_monitor_calib_gpio_regs i_dut (
    .clk(clk), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_b(gpio_oe_b),
    .mon_route(mon_route), .mon_hiz(mon_hiz), .dac_code(dac_code),
    .calib_enable(calib_enable)
  );

  pin_pullup_model i_pin (
    .gpio_out(gpio_out), .gpio_oe_b(gpio_oe_b), .ext_low(ext_low), .pin(gpio_in)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; holds the request until ack is sampled high
  task automatic bus(input logic we, input logic [4:0] idx, input logic [13:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'hf;
    dat_i <= {18'h0, wd};
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    chk({31'h0, ack_o}, 32'h1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] idx, input logic [13:0] wd);
    bus(1'b1, idx, wd);
  endtask

  task automatic rdc(input logic [4:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 14'h0000);
    chk(rd, exp);
  endtask

  // Polls the busy register until every flag has cleared
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, 5'h05, 14'h0000);
      n++;
    end while (rd !== 32'h0 && n < 40);
    chk(rd, 32'h0);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    stop_test();
  end

  initial begin
    rst_b = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 7'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    ext_low = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rdc(5'h01, 32'h0);
    chk({31'h0, mon_hiz}, 32'h1);
    rdc(5'h02, 32'h2000);
    chk({31'h0, gpio_oe_b}, 32'h1);
    rdc(5'h05, 32'h0);
    rdc(5'h00, 32'h2000);
    rdc(5'h08, 32'h0);
    rdc(5'h10, 32'h0);
    rdc(5'h18, 32'h2000);
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      wr(5'h01, 14'(3 | (1 << (i + 2))));
      rdc(5'h01, 32'(1 << (i + 2)));
      chk({20'h0, mon_route}, 32'(1 << i));
      chk({31'h0, mon_hiz}, 32'h0);
    end
    wr(5'h01, 14'h0024);
    rdc(5'h01, 32'h0024);
    chk({31'h0, mon_hiz}, 32'h1);
    $display("test monitor done");
    wr(5'h02, 14'h0000);
    repeat (4) @(posedge clk);
    chk({31'h0, gpio_oe_b}, 32'h0);
    chk({31'h0, gpio_out}, 32'h0);
    rdc(5'h02, 32'h0);
    wr(5'h02, 14'h3fff);
    repeat (4) @(posedge clk);
    chk({31'h0, gpio_oe_b}, 32'h1);
    rdc(5'h02, 32'h2000);
    ext_low <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(5'h02, 32'h0);
    ext_low <= 1'b0;
    wr(5'h03, 14'h1555);
    rdc(5'h03, 32'h0);
    wr(5'h05, 14'h3fff);
    rdc(5'h05, 32'h0);
    $display("test pin and read-only done");
    wr(5'h0b, 14'h1234);
    repeat (2) @(posedge clk);
    chk({18'h0, dac_code[3]}, 32'h1234);
    rdc(5'h05, 32'h0);
    rdc(5'h0b, 32'h1234);
    // Gain 1000h is 0.75, zero 3fffh is -1: 2000h * 0.75 - 1
    wr(5'h00, 14'h2100);
    wr(5'h1a, 14'h1000);
    chk({31'h0, calib_enable}, 32'h1);
    wr(5'h12, 14'h3fff);
    wr(5'h0a, 14'h2000);
    rdc(5'h05, 32'h0100);
    wait_idle();
    chk({18'h0, dac_code[2]}, 32'h17ff);
    rdc(5'h0a, 32'h17ff);
    wr(5'h00, 14'h0100);
    rdc(5'h0a, 32'h2000);
    // Two queued channels: one saturates high, one low
    wr(5'h1d, 14'h3fff);
    wr(5'h0d, 14'h3fff);
    wr(5'h1e, 14'h0000);
    wr(5'h16, 14'h2000);
    wr(5'h0e, 14'h0100);
    rdc(5'h05, 32'h1800);
    wait_idle();
    chk({18'h0, dac_code[5]}, 32'h3fff);
    chk({18'h0, dac_code[6]}, 32'h0);
    $display("test correction done");
    wr(5'h09, 14'h0555);
    wr(5'h00, 14'h2000);
    rdc(5'h05, 32'h0);
    chk({31'h0, calib_enable}, 32'h0);
    $display("test calibration off done");
    stop_test();
  end
endmodule
